// ===== inc/flash_defs.svh
// Constants for the paged serial flash command port.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// Opcodes
`define OP_PERMIT 8'h06
`define OP_FORBID 8'h04
`define OP_STATUS 8'h05
`define OP_REWRITE 8'h0A
`define OP_BURN 8'h02
`define OP_PAGE_CLEAR 8'hDB
`define OP_SECTOR_CLEAR 8'hD8

// Array geometry
`define MEM_BYTES 1048576
`define PAGE_LAST 16'h00FF
`define SECTOR_LAST 16'hFFFF
`define ERASED_BYTE 8'hFF

// Status register bit positions, upper bits read zero
`define STAT_BUSY_BIT 0
`define STAT_PERMIT_BIT 1

// Typical cycle times in ms, and the clock rate in kHz
`define SYS_CLK_KHZ 40000
`define T_REWRITE_MS 12
`define T_BURN_MS 2
`define T_PAGE_CLEAR_MS 10
`define T_SECTOR_CLEAR_MS 10

`endif

// ===== inc/flash_pkg.sv
// Types for the paged serial flash command port.
// Assumes flash_defs.svh supplies all numeric constants.
package flash_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    SEQ_IDLE  = 5'h01,
    SEQ_MERGE = 5'h02,
    SEQ_ERASE = 5'h04,
    SEQ_PROG  = 5'h08,
    SEQ_WAIT  = 5'h10
  } seq_t;

  // Status byte as seen by the host
  typedef struct packed {
    logic [5:0] zero;
    logic permit;
    logic busy;
  } status_t;

endpackage

// ===== src/paged_serial_flash_spi_port.sv
// Serial command port and page modify sequencer of a paged serial flash.
// Assumes sclk stops outside frames, cs_n/sdi/wp_n/reset_n are pins, and the
// host keeps cs_n low at least two sys_clk periods after the last sclk edge.
//
// How it works
// [R01] Output bit changes after each falling sclk.
// [R02] Input bits captured on rising sclk.
// [R03] Chip select high: output is high impedance.
// [R04] Deselected and idle means standby, else active.
// [R05] No command until a chip select fall.
// [R06] Reset pin low enters reset only when idle.
// [R07] Reset pin never disturbs a running cycle.
// [R08] In reset state the serial output is high impedance.
// [R09] Protect low: lowest 256 pages refuse modification.
// [R10] Protect high: lowest pages behave like others.
// [R11] Host uses clock mode 0 or mode 3.
// [R12] Host sends permit, then four bytes plus data.
// [R13] Up to 256 bytes within one page.
// [R14] Rewrite frame: opcode, three address bytes, data.
// [R15] Data fills buffer from the low address byte.
// [R16] Rewrite merges page, erases, then programs buffer.
// [R17] Burn only clears bits, never erases.
// [R18] Busy flag stands for the whole cycle.
// [R19] Host holds reset low during power-on.
// [R20] All bits travel most significant first.
// [R21] Modify commands need whole bytes or are dropped.
// [R22] Permit latch clears at reset and completion.
// [R23] Status: busy bit 0, permit bit 1.
// [R24] Data past page end wraps within page.
`timescale 1ns/10ps
`default_nettype none
`include "flash_defs.svh"

module paged_serial_flash_spi_port #(
  parameter int unsigned REWRITE_CYC = `T_REWRITE_MS * `SYS_CLK_KHZ,
  parameter int unsigned BURN_CYC = `T_BURN_MS * `SYS_CLK_KHZ,
  parameter int unsigned PAGE_CLEAR_CYC = `T_PAGE_CLEAR_MS * `SYS_CLK_KHZ,
  parameter int unsigned SECTOR_CLEAR_CYC = `T_SECTOR_CLEAR_MS * `SYS_CLK_KHZ
) (
  // System clock and block reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Device control pins
  input wire logic wp_n,
  input wire logic reset_n,
  // Loose status bits
  output logic cycle_busy_flag,
  output logic modify_permit_latch,
  output logic active_mode,
  output logic in_reset_state
);
  import flash_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the host serial clock

  logic in_frame;          // Cleared by a high chip select
  logic [2:0] bit_phase;   // Bit count modulo eight, kept after frame end
  logic [7:0] rx;          // Input shift register
  logic [7:0] byte_hold;   // Last whole byte, stable for eight edges
  logic byte_tog = 1'b0;   // Toggles once per whole byte; starts low so no false byte crosses
  logic first_done;        // Opcode byte already received
  logic rd_mode;           // Status read in progress
  logic [7:0] tx;          // Output shift register
  status_t stat_l1;        // Status crossing, first stage
  status_t stat_l2;        // Status crossing, second stage
  logic quiet_l1;          // Reset state crossing, first stage
  logic quiet_l2;          // Reset state crossing, second stage
  status_t status_now;     // Status in the system domain

  // Frame flag; chip select itself ends the frame since sclk may stop
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_frame <= 1'b0; // [R03]
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit counter restarts on the first edge of every frame
  always_ff @(posedge sclk) begin
    if (!in_frame) begin
      bit_phase <= 3'h1;
    end else begin
      bit_phase <= bit_phase + 3'h1;
    end
  end

  // Capture serial input, newest bit at the bottom
  always_ff @(posedge sclk) begin
    rx <= {rx[6:0], sdi}; // [R02] [R20]
  end

  // Hand each whole byte over with a toggle
  always_ff @(posedge sclk) begin
    if (in_frame && bit_phase == 3'h7) begin
      byte_hold <= {rx[6:0], sdi};
      byte_tog <= ~byte_tog;
    end
  end

  // Track the opcode byte and decide whether this frame reads status;
  // chip select clears it so a mode 3 leading fall never sees a stale read
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_done <= 1'b0;
      rd_mode <= 1'b0;
    end else if (in_frame && bit_phase == 3'h7 && !first_done) begin
      first_done <= 1'b1;
      rd_mode <= ({rx[6:0], sdi} == `OP_STATUS);
    end
  end

  // Status and reset state pass two flops; refreshed on every rising sclk edge
  always_ff @(posedge sclk) begin
    stat_l1 <= status_now;
    stat_l2 <= stat_l1;
    quiet_l1 <= in_reset_state;
    quiet_l2 <= quiet_l1;
  end

  // Output side: a fresh status byte at every byte boundary
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0; // [R03]
      tx <= 8'h00;
    end else begin
      sdo_oe <= rd_mode && !quiet_l2; // [R08]
      if (rd_mode && bit_phase == 3'h0) begin
        sdo <= stat_l2[7]; // [R01] [R20]
        tx <= {stat_l2[6:0], 1'b0};
      end else begin
        sdo <= tx[7]; // [R01]
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System side: pin synchronisers

  logic cs_s1, cs_s2, cs_s3;    // Chip select, two stages and an edge flop
  logic tog_s1, tog_s2, tog_s3; // Byte toggle, two stages and an edge flop
  logic [2:0] phase_s1, phase_s2; // Bit phase, read only when sclk stands
  logic wp_s1, wp_s2;           // Protect pin
  logic rpin_s1, rpin_s2;       // Reset pin
  logic cs_rise_q;              // Frame end, delayed so a last byte lands first

  // Reset to low so a chip select already low at start is no fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
      cs_s3 <= 1'b0;
      cs_rise_q <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      cs_rise_q <= cs_s2 && !cs_s3;
    end
  end

  // Remaining crossings
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      phase_s1 <= 3'h0;
      phase_s2 <= 3'h0;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      rpin_s1 <= 1'b1;
      rpin_s2 <= 1'b1;
    end else begin
      tog_s1 <= byte_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      phase_s1 <= bit_phase;
      phase_s2 <= phase_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
      rpin_s1 <= reset_n;
      rpin_s2 <= rpin_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic cs_fall;            // Frame begins
  logic byte_evt;           // A whole byte is ready in byte_hold
  logic frame_open;         // Inside a frame that began after reset
  logic [2:0] byte_idx;     // Bytes seen, saturating at four
  logic [7:0] opcode;       // First byte of frame
  logic [23:0] addr;        // Full byte address
  logic [7:0] wofs;         // Next buffer slot
  logic got_data;           // At least one data byte
  logic frame_end;          // Chip select rose on an open frame
  logic accept;             // Frame may act
  logic protect_hit;        // Target lies in the guarded pages
  logic start_op;           // Launch a sequencer cycle
  seq_t state;              // Sequencer state
  logic [31:0] timer;       // Cycle time left

  assign cs_fall = !cs_s2 && cs_s3;
  assign byte_evt = tog_s2 ^ tog_s3;
  assign frame_end = cs_rise_q && frame_open;
  // Whole bytes only, no running cycle, not in reset
  assign accept = frame_end && phase_s2 == 3'h0 && !cycle_busy_flag
    && !in_reset_state; // [R21] [R07]
  // Guarded pages are 0..255, i.e. the first 64 KB
  assign protect_hit = !wp_s2 && addr[19:16] == 4'h0; // [R09] [R10]
  assign start_op = accept && modify_permit_latch && byte_idx == 3'h4 && !protect_hit
    && ((got_data && (opcode == `OP_REWRITE || opcode == `OP_BURN))
    || (!got_data && (opcode == `OP_PAGE_CLEAR || opcode == `OP_SECTOR_CLEAR)));

  // Frame parse; opens only on a seen chip select fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_open <= 1'b0;
      byte_idx <= 3'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
      wofs <= 8'h00;
      got_data <= 1'b0;
    end else if (cs_fall) begin
      frame_open <= 1'b1; // [R05]
      byte_idx <= 3'h0;
      got_data <= 1'b0;
    end else if (frame_end) begin
      frame_open <= 1'b0;
    end else if (byte_evt && frame_open) begin
      if (byte_idx != 3'h4) begin
        byte_idx <= byte_idx + 3'h1;
      end
      case (byte_idx)
        3'h0: opcode <= byte_hold;
        3'h1, 3'h2: addr <= {addr[15:0], byte_hold}; // [R14]
        3'h3: begin
          addr <= {addr[15:0], byte_hold};
          wofs <= byte_hold; // [R15]
        end
        default: begin
          got_data <= 1'b1;
          wofs <= wofs + 8'h01; // [R24] [R13]
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset state, permit latch and status outputs

  // Reset pin takes effect only between cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_reset_state <= 1'b0;
    end else begin
      in_reset_state <= !rpin_s2 && (state == SEQ_IDLE) && !start_op; // [R06] [R07]
    end
  end

  // Permit latch; completion and forbid clear it
  always_ff @(posedge sys_clk) begin
    if (rst || in_reset_state) begin
      modify_permit_latch <= 1'b0; // [R22]
    end else if (state == SEQ_WAIT && timer == 32'h0) begin
      modify_permit_latch <= 1'b0; // [R22]
    end else if (accept && byte_idx == 3'h1 && opcode == `OP_FORBID) begin
      modify_permit_latch <= 1'b0; // [R22]
    end else if (accept && byte_idx == 3'h1 && opcode == `OP_PERMIT) begin
      modify_permit_latch <= 1'b1;
    end
  end

  // Standby versus active
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_mode <= 1'b0;
    end else begin
      active_mode <= !cs_s2 || cycle_busy_flag; // [R04]
    end
  end

  always_comb begin
    status_now = '0; // [R23]
    status_now.busy = cycle_busy_flag;
    status_now.permit = modify_permit_latch;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Page buffer and array

  logic [7:0] mem [0:`MEM_BYTES-1]; // The flash array
  logic [7:0] pbuf [0:255];         // Page buffer
  logic [255:0] touched;            // Slots loaded by the host
  logic [15:0] idx;                 // Sequencer walk index
  logic [7:0] op;                   // Command in progress
  logic [19:0] base;                // Target address
  logic [19:0] mem_addr;            // Array address under the walk
  logic [7:0] mem_rd;               // Array read data
  logic [15:0] walk_last;           // Last index of an erase walk

  assign mem_addr = (op == `OP_SECTOR_CLEAR) ? {base[19:16], idx}
    : {base[19:8], idx[7:0]};
  assign mem_rd = mem[mem_addr];
  assign walk_last = (op == `OP_SECTOR_CLEAR) ? `SECTOR_LAST : `PAGE_LAST;

  // Host data fills the buffer; merge fills the untouched slots
  always_ff @(posedge sys_clk) begin
    if (state == SEQ_MERGE) begin
      if (!touched[idx[7:0]]) begin
        pbuf[idx[7:0]] <= mem_rd; // [R16]
      end
    end else if (byte_evt && frame_open && byte_idx == 3'h4 && !cycle_busy_flag) begin
      pbuf[wofs] <= byte_hold; // [R15] [R24]
    end
  end

  // Slot markers, cleared at each frame start made while no cycle runs
  always_ff @(posedge sys_clk) begin
    if (rst || (cs_fall && !cycle_busy_flag)) begin
      touched <= '0;
    end else if (byte_evt && frame_open && byte_idx == 3'h4 && !cycle_busy_flag) begin
      touched[wofs] <= 1'b1;
    end
  end

  // Array writes: erase sets all ones, program only clears bits
  always_ff @(posedge sys_clk) begin
    if (state == SEQ_ERASE) begin
      mem[mem_addr] <= `ERASED_BYTE; // [R16]
    end else if (state == SEQ_PROG) begin
      if (op == `OP_REWRITE) begin
        mem[mem_addr] <= pbuf[idx[7:0]]; // [R16]
      end else if (touched[idx[7:0]]) begin
        mem[mem_addr] <= mem_rd & pbuf[idx[7:0]]; // [R17]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer; busy spans the walk and the full cycle time

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SEQ_IDLE;
      cycle_busy_flag <= 1'b0;
      idx <= 16'h0000;
      timer <= 32'h0;
      op <= 8'h00;
      base <= 20'h00000;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        SEQ_IDLE: begin
          if (start_op) begin
            cycle_busy_flag <= 1'b1; // [R18]
            op <= opcode;
            base <= addr[19:0];
            idx <= 16'h0000;
            case (opcode)
              `OP_REWRITE: begin
                state <= SEQ_MERGE; // [R16]
                timer <= REWRITE_CYC;
              end
              `OP_BURN: begin
                state <= SEQ_PROG; // [R17]
                timer <= BURN_CYC;
              end
              `OP_PAGE_CLEAR: begin
                state <= SEQ_ERASE;
                timer <= PAGE_CLEAR_CYC;
              end
              default: begin
                state <= SEQ_ERASE;
                timer <= SECTOR_CLEAR_CYC;
              end
            endcase
          end
        end
        SEQ_MERGE: begin
          idx <= (idx == `PAGE_LAST) ? 16'h0000 : idx + 16'h0001;
          if (idx == `PAGE_LAST) begin
            state <= SEQ_ERASE;
          end
        end
        SEQ_ERASE: begin
          idx <= (idx == walk_last) ? 16'h0000 : idx + 16'h0001;
          if (idx == walk_last) begin
            state <= (op == `OP_REWRITE) ? SEQ_PROG : SEQ_WAIT;
          end
        end
        SEQ_PROG: begin
          idx <= (idx == `PAGE_LAST) ? 16'h0000 : idx + 16'h0001;
          if (idx == `PAGE_LAST) begin
            state <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (timer == 32'h0) begin
            state <= SEQ_IDLE;
            cycle_busy_flag <= 1'b0; // [R18]
          end
        end
        default: begin
          state <= SEQ_IDLE;
          cycle_busy_flag <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== dv/flash_port_properties.sv
// Concurrent checks on the pins of the paged serial flash command port.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module flash_port_properties #(
  parameter int unsigned REWRITE_CYC = 480000,
  parameter int unsigned BURN_CYC = 80000,
  parameter int unsigned PAGE_CLEAR_CYC = 400000,
  parameter int unsigned SECTOR_CLEAR_CYC = 400000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // Control pins
  input wire logic wp_n,
  input wire logic reset_n,
  // Status bits
  input wire logic cycle_busy_flag,
  input wire logic modify_permit_latch,
  input wire logic active_mode,
  input wire logic in_reset_state
);
  // Shortest cycle time of any modify command
  localparam int MIN_A = (REWRITE_CYC < BURN_CYC) ? REWRITE_CYC : BURN_CYC;
  localparam int MIN_B = (PAGE_CLEAR_CYC < SECTOR_CLEAR_CYC) ? PAGE_CLEAR_CYC : SECTOR_CLEAR_CYC;
  localparam int MIN_CYC = (MIN_A < MIN_B) ? MIN_A : MIN_B;
  int busy_len; // Cycles spent busy so far

  ////////////////////////////////////////////////////////////////////////////////
  // Busy length counter, cleared while idle so each cycle is measured alone
  always_ff @(posedge sys_clk) begin
    if (rst || !cycle_busy_flag) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_SDO_FALL_ONLY: assert property (!$fell(sclk) && !cs_n && $past(sdo_oe) && sdo_oe
    |-> $stable(sdo)) else $error("Serial output moved without a falling clock");
  AST_OE_DESELECT: assert property (cs_n |-> !sdo_oe)
    else $error("Output driven while deselected");
  AST_OE_RESET: assert property (in_reset_state |-> !sdo_oe)
    else $error("Output driven in reset state");
  AST_ACTIVE_SEL: assert property ((!cs_n) [*5] |-> active_mode)
    else $error("Not active while selected");
  AST_STANDBY: assert property ((cs_n && !cycle_busy_flag) [*5] |-> !active_mode)
    else $error("Not in standby while idle and deselected");
  AST_RESET_ENTRY: assert property ($fell(reset_n) && !cycle_busy_flag
    |-> ##[1:6] in_reset_state) else $error("Reset state not entered");
  AST_RESET_HOLDOFF: assert property (cycle_busy_flag |-> !in_reset_state)
    else $error("Reset state entered during a cycle");
  AST_CYCLE_START: assert property ($rose(cycle_busy_flag)
    |-> cs_n && $past(cs_n, 2) && modify_permit_latch) else $error("Cycle began wrongly");
  AST_BUSY_LEN: assert property ($fell(cycle_busy_flag) |-> busy_len >= MIN_CYC - 2)
    else $error("Busy flag dropped early");
  AST_PERMIT_DONE: assert property ($fell(cycle_busy_flag) |-> !modify_permit_latch)
    else $error("Permit latch kept after cycle");
  AST_RST_CLEAR: assert property (disable iff (1'b0) rst |=> !cycle_busy_flag
    && !modify_permit_latch && !in_reset_state) else $error("Block reset left state set");
endmodule

bind paged_serial_flash_spi_port flash_port_properties #(.REWRITE_CYC(REWRITE_CYC),
  .BURN_CYC(BURN_CYC), .PAGE_CLEAR_CYC(PAGE_CLEAR_CYC), .SECTOR_CLEAR_CYC(SECTOR_CLEAR_CYC))
  props_u (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
  .sdo_oe(sdo_oe), .wp_n(wp_n), .reset_n(reset_n), .cycle_busy_flag(cycle_busy_flag),
  .modify_permit_latch(modify_permit_latch), .active_mode(active_mode),
  .in_reset_state(in_reset_state));
`default_nettype wire

// ===== dv/spi_host_model.sv
// Behavioural SPI host controller that frames commands for the flash port.
// Assumes the bench fills tx_q and calls frame; clock runs only inside frames.
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  // Serial link pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic mode3 = 1'b0; // Clock idles high when set
  logic [7:0] tx_q[$]; // Bytes of the next frame
  logic [7:0] rx_byte; // Last byte read back
  logic rx_oe; // Output enable seen on every read bit

  initial begin
    sclk = 1'b0;
    cs_n = 1'b0; // Power-up: the pin rises once, giving the link flops a defined start
    sdi = 1'b0;
    #5 cs_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bit per 64 ns period, most significant first
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      if (mode3) sclk = 1'b0;
      sdi = b[i];
      #32 sclk = 1'b1;
      rx_byte = {rx_byte[6:0], sdo_oe ? sdo : ~rx_byte[0]}; // Released line keeps no stale bit
      rx_oe = rx_oe & sdo_oe;
      #32 if (!mode3) sclk = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Whole frame; extra stray bits break the byte boundary on purpose
  task automatic frame(input int extra, input int nread);
    sclk = mode3;
    #40 cs_n = 1'b0;
    #20;
    foreach (tx_q[k]) shift(tx_q[k], 8);
    if (extra > 0) shift(8'hA5, extra);
    rx_oe = 1'b1;
    for (int k = 0; k < nread; k++) shift(8'h00, 8);
    #60 cs_n = 1'b1;
    sdi = ~sdi; // Released line must not keep its last level
    tx_q.delete();
    #200;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the flash command port, host model on the link.
// Assumes shortened cycle timers; judged at the pins plus a peek at the array.
`timescale 1ns/10ps
`default_nettype none
`include "flash_defs.svh"

module tb;
  import flash_pkg::*;
  localparam int unsigned CYC = 1000; // Shortened cycle timers
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b0;
  logic reset_n = 1'b0;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe, busy, permit, active, in_rst;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [23:0] adr; // Target of the wrap scenario
  logic [7:0] sent[$]; // Data bytes of the last frame sent
  logic [7:0] ops[3] = '{`OP_REWRITE, `OP_BURN, `OP_PAGE_CLEAR};

  paged_serial_flash_spi_port #(.REWRITE_CYC(CYC), .BURN_CYC(CYC), .PAGE_CLEAR_CYC(CYC),
    .SECTOR_CLEAR_CYC(CYC)) dut_u (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .wp_n(wp_n), .reset_n(reset_n),
    .cycle_busy_flag(busy), .modify_permit_latch(permit), .active_mode(active),
    .in_reset_state(in_rst));
  spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;

  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("Error at %0t: run did not finish", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Expected status byte, upper bits zero
  function automatic logic [7:0] stat(input logic b, input logic p);
    status_t s;
    s = '0;
    s.busy = b;
    s.permit = p;
    return s;
  endfunction

  // Random address, in sector 0 when protected is asked for
  function automatic logic [23:0] rand_adr(input logic low);
    return {4'h0, low ? 4'h0 : 4'($urandom_range(15, 1)), 16'($urandom)};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] op, input logic [23:0] adr, input int nab,
                      input int nd, input int extra);
    host_u.tx_q.push_back(op);
    for (int k = 2; k >= 3 - nab; k--) host_u.tx_q.push_back(adr[8*k +: 8]);
    sent.delete();
    repeat (nd) sent.push_back(8'($urandom));
    foreach (sent[k]) host_u.tx_q.push_back(sent[k]);
    host_u.frame(extra, 0);
    settle(8);
  endtask

  task automatic status(input logic [7:0] exp);
    host_u.tx_q.push_back(`OP_STATUS);
    host_u.frame(0, 1);
    check(host_u.rx_byte, exp, "status byte");
  endtask

  // Permit, modify, poll, reset pin mid-cycle, wait for the end
  task automatic run_cycle(input logic [7:0] op, input logic [23:0] adr, input int nd);
    int n;
    n = 0;
    send(`OP_PERMIT, 24'h0, 0, 0, 0);
    send(op, adr, 3, nd, 0);
    check({7'h00, busy}, 8'h01, "cycle start");
    status(stat(1'b1, 1'b1));
    reset_n = 1'b0;
    settle(20);
    check({7'h00, in_rst}, 8'h00, "reset during cycle");
    reset_n = 1'b1;
    while (busy === 1'b1 && n < 5 * CYC) begin
      settle(1);
      n++;
    end
    check({7'h00, n > CYC - 200 && n < CYC + 200}, 8'h01, "cycle length");
    status(stat(1'b0, 1'b0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h20C9772B));
    settle(5);
    rst = 1'b0;
    settle(6);
    check({7'h00, in_rst}, 8'h01, "reset pin at power-on");
    reset_n = 1'b1;
    settle(8);
    status(stat(1'b0, 1'b0));
    send(`OP_PERMIT, 24'h0, 0, 0, 0);
    status(stat(1'b0, 1'b1));
    send(`OP_FORBID, 24'h0, 0, 0, 0);
    status(stat(1'b0, 1'b0));
    send(`OP_BURN, rand_adr(1'b0), 3, 2, 0);
    status(stat(1'b0, 1'b0));
    send(`OP_PERMIT, 24'h0, 0, 0, 0);
    send(`OP_BURN, rand_adr(1'b0), 3, 2, 3);
    status(stat(1'b0, 1'b1));
    send(`OP_BURN, rand_adr(1'b1), 3, 4, 0);
    send(`OP_SECTOR_CLEAR, 24'h000000, 3, 0, 0);
    send(`OP_PAGE_CLEAR, rand_adr(1'b1), 3, 0, 0);
    status(stat(1'b0, 1'b1));
    for (int m = 0; m < 2; m++) begin
      host_u.mode3 = m[0];
      foreach (ops[i]) run_cycle(ops[i], rand_adr(1'b0), (i == 2) ? 0 : $urandom_range(4, 1));
    end
    adr = rand_adr(1'b0);
    run_cycle(`OP_REWRITE, adr, 260);
    // Every slot ends with the last byte sent to it, after wrapping
    for (int k = 4; k < 260; k++) begin
      check(dut_u.mem[{adr[19:8], 8'(adr[7:0] + k)}], sent[k], "page byte");
    end
    wp_n = 1'b1;
    run_cycle(`OP_BURN, rand_adr(1'b1), 3);
    send(`OP_PERMIT, 24'h0, 0, 0, 0);
    reset_n = 1'b0;
    settle(8);
    check({7'h00, in_rst}, 8'h01, "reset state entry");
    host_u.tx_q.push_back(`OP_STATUS);
    host_u.frame(0, 1);
    check({7'h00, host_u.rx_oe}, 8'h00, "output in reset");
    reset_n = 1'b1;
    settle(8);
    status(stat(1'b0, 1'b0));
    check({7'h00, active}, 8'h00, "standby");
    close_out();
  end
endmodule
`default_nettype wire
